// [rtl/nvt_engine.sv]
// Program, erase and blank-check timing engine
// Notes on behaviour
// RL1: Time base from divided oscillator; no frequency check ever blocks commands.
// RL2: Software sets dividers for a 150 to 200 kHz operation clock.
// RL3: Single word program lasts 9 operation periods plus 25 bus cycles.
// RL4: Flash only bursts up to 32 words while the command pipeline stays filled.
// RL5: Each later burst word takes 4 operation periods plus 9 bus cycles.
// RL6: Sector erase takes about 4000 operation periods, no setup.
// RL7: Mass erase takes about 20000 operation periods, no setup.
// RL8: Blank check scans one word per cycle, stops at non-blank, plus 10 setup.
// RL9: Bus clock held at 1 MHz or more during program or erase.
// RL10: Busy held from launch until the timed operation fully completes.
`timescale 1ns/10ps
`default_nettype none
module nvt_engine
	import nvt_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic osc_tick,
	input wire logic [nvt_pkg::DIV_W-1:0] flash_clock_divider,
	input wire logic [nvt_pkg::DIV_W-1:0] eeprom_clock_divider,
	input wire logic cmd_valid,
	input wire nvt_pkg::nvt_cmd_t cmd_code,
	input wire logic cmd_eeprom,
	input wire logic [nvt_pkg::CNT_W-1:0] blank_words,
	input wire logic word_blank,
	output logic cmd_ready,
	output logic busy,
	output logic done,
	output logic blank_fail,
	output logic [nvt_pkg::CNT_W-1:0] scan_addr,
	output logic nvm_operation_clock
);
	import nvt_pkg::*;

	nvt_state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next, opcnt_reg, opcnt_next;
	logic [DIV_W-1:0] div_reg, div_next;
	logic [5:0] burst_reg, burst_next;
	logic eeprom_reg, eeprom_next, pgm_reg, pgm_next;
	logic busy_reg, busy_next, done_reg, done_next, fail_reg, fail_next;
	logic ready_reg, ready_next;
	logic [CNT_W-1:0] addr_reg, addr_next;
	logic opclk_reg, opclk_next, op_tick;
	logic [DIV_W-1:0] div_sel;

	// Divider runs on oscillator ticks and restarts on entry to ST_OP; no range check (RL1)
	assign div_sel = eeprom_reg ? eeprom_clock_divider : flash_clock_divider;
	// At or above: a divider switched to a smaller value must not wrap all the way round
	assign op_tick = osc_tick && (div_reg >= div_sel);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		opcnt_next = opcnt_reg;
		burst_next = burst_reg;
		eeprom_next = eeprom_reg;
		pgm_next = pgm_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		fail_next = fail_reg;
		addr_next = addr_reg;
		div_next = div_reg;
		opclk_next = opclk_reg;
		if (osc_tick) begin
			div_next = op_tick ? '0 : div_reg + 1'b1;
			if (op_tick) begin
				opclk_next = ~opclk_reg;
			end
		end
		unique case (state_reg)
			ST_IDLE: begin
				if (cmd_valid) begin
					// Launch sets busy (RL10)
					busy_next = 1'b1;
					eeprom_next = cmd_eeprom;
					fail_next = 1'b0;
					burst_next = '0;
					pgm_next = 1'b0;
					unique case (cmd_code)
						CMD_PROGRAM: begin
							// RL3 single word timing
							pgm_next = 1'b1;
							cnt_next = SWPGM_BUS;
							opcnt_next = SWPGM_OP;
							state_next = ST_BUS;
						end
						CMD_SECTOR_ERASE: begin
							// RL6 sector erase
							opcnt_next = ERASE_OP;
							state_next = ST_OP;
						end
						CMD_MASS_ERASE: begin
							// RL7 mass erase
							opcnt_next = MASS_OP;
							state_next = ST_OP;
						end
						default: begin
							// RL8 blank check setup
							cnt_next = BLANK_SETUP;
							addr_next = '0;
							state_next = ST_SCAN;
						end
					endcase
				end
			end
			ST_BUS: begin
				cnt_next = cnt_reg - ONE;
				if (cnt_reg == ONE) begin
					state_next = ST_OP;
				end
			end
			ST_OP: begin
				if (op_tick) begin
					opcnt_next = opcnt_reg - ONE;
					if (opcnt_reg == ONE) begin
						// RL4 burst continues only on a queued flash program
						if (pgm_reg && !eeprom_reg && cmd_valid && cmd_code == CMD_PROGRAM
								&& !cmd_eeprom && burst_reg < BURST_MAX - 6'h01) begin
							burst_next = burst_reg + 6'h01;
							// RL5 shorter burst word
							cnt_next = BWPGM_BUS;
							opcnt_next = BWPGM_OP;
							state_next = ST_BUS;
						end else begin
							// RL10 clear busy at completion
							busy_next = 1'b0;
							done_next = 1'b1;
							state_next = ST_IDLE;
						end
					end
				end
			end
			ST_SCAN: begin
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - ONE;
				end else if (!word_blank || addr_reg == blank_words) begin
					// RL8 stop at first non-blank word
					fail_next = !word_blank && addr_reg != blank_words;
					busy_next = 1'b0;
					done_next = 1'b1;
					state_next = ST_IDLE;
				end else begin
					addr_next = addr_reg + ONE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
		// RL3 whole first period
		// Restart divider on entry; a free-running phase would cut the first period short
		if (state_next == ST_OP && state_reg != ST_OP) begin
			div_next = '0;
		end
		ready_next = !busy_next;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			opcnt_reg <= '0;
			burst_reg <= '0;
			eeprom_reg <= 1'b0;
			pgm_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			addr_reg <= '0;
			div_reg <= '0;
			opclk_reg <= 1'b0;
			ready_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			opcnt_reg <= opcnt_next;
			burst_reg <= burst_next;
			eeprom_reg <= eeprom_next;
			pgm_reg <= pgm_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			fail_reg <= fail_next;
			addr_reg <= addr_next;
			div_reg <= div_next;
			opclk_reg <= opclk_next;
			ready_reg <= ready_next;
		end
	end

	assign busy = busy_reg;
	assign cmd_ready = ready_reg;
	assign done = done_reg;
	assign blank_fail = fail_reg;
	assign scan_addr = addr_reg;
	assign nvm_operation_clock = opclk_reg;

	// Reference counters for checks
	logic [CNT_W-1:0] run_len;
	always_ff @(posedge clk) begin
		if (sys_rst || !busy_reg) begin
			run_len <= '0;
		end else begin
			run_len <= run_len + ONE;
		end
	end
	// Cycles spent so far in the current bus-count phase
	logic [CNT_W-1:0] bus_run;
	always_ff @(posedge clk) begin
		if (sys_rst || state_reg != ST_BUS) begin
			bus_run <= '0;
		end else begin
			bus_run <= bus_run + ONE;
		end
	end

	sequence s_launch;
		state_reg == ST_IDLE && cmd_valid;
	endsequence
	sequence s_busy_hold;
		busy_reg [*8];
	endsequence

	property p_launch_busy;
		@(posedge clk) disable iff (sys_rst) s_launch |=> s_busy_hold or (busy_reg ##1 !busy_reg);
	endproperty
	a_launch_busy: assert property (p_launch_busy) else $error("busy not set at launch"); // RL10

	property p_done_clears;
		@(posedge clk) disable iff (sys_rst) done_reg |-> !busy_reg && $past(busy_reg);
	endproperty
	a_done_clears: assert property (p_done_clears) else $error("done without busy end"); // RL10

	property p_pgm_bus;
		@(posedge clk) disable iff (sys_rst)
			(s_launch and (cmd_code == CMD_PROGRAM)) |=> state_reg == ST_BUS && bus_run == '0;
	endproperty
	a_pgm_bus: assert property (p_pgm_bus) else $error("program not opened by bus phase"); // RL3

	property p_pgm_bus_len;
		@(posedge clk) disable iff (sys_rst)
			state_reg == ST_BUS && state_next != ST_BUS && burst_reg == '0
				|-> bus_run == SWPGM_BUS - ONE;
	endproperty
	a_pgm_bus_len: assert property (p_pgm_bus_len) else $error("program bus phase not 25"); // RL3

	property p_blank_setup;
		@(posedge clk) disable iff (sys_rst)
			state_reg == ST_SCAN && cnt_reg == '0 |-> run_len == BLANK_SETUP + addr_reg;
	endproperty
	a_blank_setup: assert property (p_blank_setup) else $error("blank setup not 10"); // RL8

	property p_blank_len;
		@(posedge clk) disable iff (sys_rst)
			done_reg && $past(state_reg) == ST_SCAN
				|-> run_len == $past(run_len) + ONE
				&& $past(run_len) == addr_reg + BLANK_SETUP;
	endproperty
	a_blank_len: assert property (p_blank_len) else $error("blank check length wrong"); // RL8

	property p_burst_cap;
		@(posedge clk) disable iff (sys_rst) burst_reg < BURST_MAX;
	endproperty
	a_burst_cap: assert property (p_burst_cap) else $error("burst over 32 words"); // RL4

	property p_no_eep_burst;
		@(posedge clk) disable iff (sys_rst) eeprom_reg && busy_reg |-> burst_reg == '0;
	endproperty
	a_no_eep_burst: assert property (p_no_eep_burst) else $error("eeprom burst"); // RL4

	property p_burst_bus;
		@(posedge clk) disable iff (sys_rst)
			state_reg == ST_BUS && state_next != ST_BUS && burst_reg != '0
				|-> bus_run == BWPGM_BUS - ONE;
	endproperty
	a_burst_bus: assert property (p_burst_bus) else $error("burst bus phase not 9"); // RL5

	property p_erase_count;
		@(posedge clk) disable iff (sys_rst)
			(s_launch and (cmd_code == CMD_SECTOR_ERASE))
				|=> opcnt_reg == ERASE_OP && state_reg == ST_OP;
	endproperty
	a_erase_count: assert property (p_erase_count) else $error("sector erase count"); // RL6

	property p_mass_count;
		@(posedge clk) disable iff (sys_rst)
			(s_launch and (cmd_code == CMD_MASS_ERASE))
				|=> opcnt_reg == MASS_OP && state_reg == ST_OP;
	endproperty
	a_mass_count: assert property (p_mass_count) else $error("mass erase count"); // RL7

	property p_no_block;
		@(posedge clk) disable iff (sys_rst) s_launch |=> busy_reg;
	endproperty
	a_no_block: assert property (p_no_block) else $error("command blocked"); // RL1
endmodule
`default_nettype wire

// [shared/nvt_pkg.sv]
// Package for the non-volatile memory program and erase timing engine
package nvt_pkg;
	localparam int DIV_W = 8;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] SWPGM_OP = 16'h0009;
	localparam logic [CNT_W-1:0] SWPGM_BUS = 16'h0019;
	localparam logic [CNT_W-1:0] BWPGM_OP = 16'h0004;
	localparam logic [CNT_W-1:0] BWPGM_BUS = 16'h0009;
	localparam logic [CNT_W-1:0] ERASE_OP = 16'h0FA0;
	localparam logic [CNT_W-1:0] MASS_OP = 16'h4E20;
	localparam logic [CNT_W-1:0] BLANK_SETUP = 16'h000A;
	localparam logic [CNT_W-1:0] ONE = 16'h0001;
	localparam logic [5:0] BURST_MAX = 6'h20;
	typedef enum logic [2:0] {
		CMD_PROGRAM,
		CMD_SECTOR_ERASE,
		CMD_MASS_ERASE,
		CMD_BLANK_CHECK
	} nvt_cmd_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_BUS,
		ST_OP,
		ST_SCAN
	} nvt_state_t;
endpackage

// [sim/nvt_engine_bench.sv]
// Self-checking bench for the program, erase and blank-check timing engine
`timescale 1ns/10ps
`default_nettype none
module nvt_engine_bench;
	import nvt_pkg::*;
	logic clk, sys_rst, osc_tick, cmd_valid, cmd_eeprom, word_blank;
	logic cmd_ready, busy, done, blank_fail, nvm_operation_clock;
	logic [DIV_W-1:0] fdiv, ediv;
	logic [CNT_W-1:0] blank_words, scan_addr, fail_loc, cnt, loc;
	nvt_cmd_t cmd_code;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	int error_cnt, n_tests, seed, k;
	nvt_engine DUT (.clk(clk), .sys_rst(sys_rst), .osc_tick(osc_tick),
		.flash_clock_divider(fdiv), .eeprom_clock_divider(ediv), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_eeprom(cmd_eeprom), .blank_words(blank_words),
		.word_blank(word_blank), .cmd_ready(cmd_ready), .busy(busy), .done(done),
		.blank_fail(blank_fail), .scan_addr(scan_addr),
		.nvm_operation_clock(nvm_operation_clock));
	// Array model: a single dirty word at fail_loc
	assign word_blank = (scan_addr != fail_loc);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Busy cycles counted per command; a done with no note is an error
	always @(posedge clk) begin
		if (sys_rst)
			cnt <= 16'h0000;
		else if (done === 1'b1) begin
			if (exp_q.size() == 0)
				check(32'h1, 32'h0);
			else begin
				e = exp_q.pop_front();
				check({16'h0, cnt}, {16'h0, e[15:0]});
				check({31'h0, blank_fail}, {31'h0, e[32]});
				if (e[31:16] != 16'hFFFF)
					check({16'h0, scan_addr}, {16'h0, e[31:16]});
			end
			cnt <= 16'h0000;
		end else if (busy === 1'b1)
			cnt <= cnt + 16'h0001;
		if (!sys_rst)
			check({31'h0, cmd_ready}, {31'h0, ~busy});
	end
	task automatic wait_done;
		int i;
		for (i = 0; i < 50000 && done !== 1'b1; i++)
			@(negedge clk);
		if (done !== 1'b1)
			check(32'h1, 32'h0);
		@(posedge clk);
		#1;
	endtask
	// One command; hold keeps the request up until completion
	task automatic go(input nvt_cmd_t c, input logic ee, input logic [32:0] x, input bit hold);
		exp_q.push_back(x);
		cmd_code = c;
		cmd_eeprom = ee;
		cmd_valid = 1'b1;
		if (hold) begin
			wait_done();
			// Request still up at the done edge relaunches one single word
			exp_q.push_back({x[32:16], ee ? 16'h002B : 16'h0022});
		end else
			@(posedge clk);
		#1 cmd_valid = 1'b0;
		wait_done();
	endtask
	initial begin
		#(50 * 60000);
		error_cnt++;
		summarize();
	end
	initial begin
		seed = 32'h19E3;
		{sys_rst, osc_tick, cmd_valid, cmd_eeprom} = 4'hC;
		cmd_code = CMD_PROGRAM;
		fdiv = 8'h00;
		ediv = 8'h01;
		blank_words = 16'h0040;
		fail_loc = 16'hFFFF;
		repeat (16) @(posedge clk);
		#1 sys_rst = 1'b0;
		check({31'h0, busy}, 32'h0);
		// flash word, then divided EEPROM clock
		go(CMD_PROGRAM, 1'b0, {17'h0FFFF, 16'h0022}, 0);
		go(CMD_PROGRAM, 1'b1, {17'h0FFFF, 16'h002B}, 0);
		$display("program done");
		// a stray erase while busy is ignored
		exp_q.push_back({17'h0FFFF, 16'h0022});
		cmd_code = CMD_PROGRAM;
		cmd_eeprom = 1'b0;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		repeat (5) @(posedge clk);
		#1 cmd_code = CMD_SECTOR_ERASE;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		wait_done();
		$display("refusal done");
		// full flash row, EEPROM never bursts
		go(CMD_PROGRAM, 1'b0, {17'h0FFFF, 16'h01B5}, 1);
		go(CMD_PROGRAM, 1'b1, {17'h0FFFF, 16'h002B}, 1);
		$display("burst done");
		// erase at an out-of-range fast clock
		go(CMD_SECTOR_ERASE, 1'b0, {17'h0FFFF, 16'h0FA0}, 0);
		// EEPROM divider of one gives two bus cycles per operation period
		go(CMD_MASS_ERASE, 1'b1, {17'h0FFFF, 16'h9C40}, 0);
		$display("erase done");
		// random dirty word, then a clean block
		for (k = 0; k < 3; k++) begin
			loc = 16'($random(seed)) & 16'h003F;
			fail_loc = loc;
			go(CMD_BLANK_CHECK, k[0], {1'b1, loc, loc + 16'h000B}, 0);
		end
		fail_loc = 16'hFFFF;
		go(CMD_BLANK_CHECK, 1'b0, {1'b0, blank_words, blank_words + 16'h000B}, 0);
		go(CMD_PROGRAM, 1'b0, {17'h0FFFF, 16'h0022}, 0);
		$display("blank check done");
		summarize();
	end
endmodule
`default_nettype wire
